// *** tsq_sequencer.sv ***
// TMS sequencer for moves starting in Pause-DR, Pause-IR, Shift-DR, Shift-IR
//
// Overview of operation
// - Pause-DR: hold low; exit sequences to TLR/RTI/Shift-DR
// - Pause-DR to Pause-DR, Shift-IR, Pause-IR sequences
// - Pause-IR: hold low; exit sequences to TLR/RTI/Shift-IR
// - Pause-IR to Shift-DR, Pause-DR, Pause-IR sequences
// - Shift-DR: hold low; exits to TLR/RTI/Pause-DR
// - Shift-DR to Pause-IR: H,H,H,H,L,H,L
// - Shift-IR: hold low; exits to TLR/RTI/Pause-IR
// - Shift-IR to Pause-DR: H,H,H,L,H,L
// - Current TAP state always readable, four bits
// - Buffer stall: pause if free-running, else stay
`include "tsq_regs.svh"

module tsq_sequencer (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic tck,
    input wire logic cmd_valid,
    input wire tsq_pkg::tsq_tap_t cmd_end_state,
    output logic cmd_ready,
    output logic cmd_rejected,
    input wire logic buffer_stall,
    input wire logic gated_mode,
    output logic tms,
    output tsq_pkg::tsq_tap_t current_tap_state_field,
    output logic busy
);
    import tsq_pkg::*;

    // ----------------------------------------------------------------
    // Standard TAP graph and sequence table
    // ----------------------------------------------------------------
    function automatic tsq_tap_t tap_next(input tsq_tap_t s, input logic m);
        case (s)
            `TSQ_TLR: tap_next = m ? `TSQ_TLR : `TSQ_RTI;
            `TSQ_RTI: tap_next = m ? `TSQ_SDRS : `TSQ_RTI;
            `TSQ_SDRS: tap_next = m ? `TSQ_SIRS : `TSQ_CDR;
            `TSQ_CDR: tap_next = m ? `TSQ_E1DR : `TSQ_SDR;
            `TSQ_SDR: tap_next = m ? `TSQ_E1DR : `TSQ_SDR;
            `TSQ_E1DR: tap_next = m ? `TSQ_UDR : `TSQ_PDR;
            `TSQ_PDR: tap_next = m ? `TSQ_E2DR : `TSQ_PDR;
            `TSQ_E2DR: tap_next = m ? `TSQ_UDR : `TSQ_SDR;
            `TSQ_UDR: tap_next = m ? `TSQ_SDRS : `TSQ_RTI;
            `TSQ_SIRS: tap_next = m ? `TSQ_TLR : `TSQ_CIR;
            `TSQ_CIR: tap_next = m ? `TSQ_E1IR : `TSQ_SIR;
            `TSQ_SIR: tap_next = m ? `TSQ_E1IR : `TSQ_SIR;
            `TSQ_E1IR: tap_next = m ? `TSQ_UIR : `TSQ_PIR;
            `TSQ_PIR: tap_next = m ? `TSQ_E2IR : `TSQ_PIR;
            `TSQ_E2IR: tap_next = m ? `TSQ_UIR : `TSQ_SIR;
            default: tap_next = m ? `TSQ_SDRS : `TSQ_RTI;
        endcase
    endfunction

    // Returns {supported, length, levels}
    function automatic logic [10:0] seq_lookup(input tsq_tap_t s, input tsq_tap_t e);
        seq_lookup = 11'h000;
        if (e == `TSQ_TLR && (s == `TSQ_PDR || s == `TSQ_PIR || s == `TSQ_SDR
                || s == `TSQ_SIR)) begin
            seq_lookup = {1'b1, `TSQ_LEN_TLR, `TSQ_SEQ_TLR};
        end else if (e == `TSQ_RTI && (s == `TSQ_PDR || s == `TSQ_PIR
                || s == `TSQ_SDR || s == `TSQ_SIR)) begin
            seq_lookup = {1'b1, `TSQ_LEN_RTI, `TSQ_SEQ_RTI};
        end else begin
            case ({s, e})
                {`TSQ_PDR, `TSQ_SDR}: seq_lookup = {1'b1, `TSQ_LEN_HL, `TSQ_SEQ_HL};
                {`TSQ_PDR, `TSQ_PDR}:
                    seq_lookup = {1'b1, `TSQ_LEN_TO_PDR, `TSQ_SEQ_TO_PDR};
                {`TSQ_PDR, `TSQ_SIR}:
                    seq_lookup = {1'b1, `TSQ_LEN_PDR_SIR, `TSQ_SEQ_PDR_SIR};
                {`TSQ_PDR, `TSQ_PIR}:
                    seq_lookup = {1'b1, `TSQ_LEN_TO_PIR, `TSQ_SEQ_TO_PIR};
                {`TSQ_PIR, `TSQ_SIR}: seq_lookup = {1'b1, `TSQ_LEN_HL, `TSQ_SEQ_HL};
                {`TSQ_PIR, `TSQ_SDR}:
                    seq_lookup = {1'b1, `TSQ_LEN_PIR_SDR, `TSQ_SEQ_PIR_SDR};
                {`TSQ_PIR, `TSQ_PDR}:
                    seq_lookup = {1'b1, `TSQ_LEN_TO_PDR, `TSQ_SEQ_TO_PDR};
                {`TSQ_PIR, `TSQ_PIR}:
                    seq_lookup = {1'b1, `TSQ_LEN_TO_PIR, `TSQ_SEQ_TO_PIR};
                {`TSQ_SDR, `TSQ_PDR}: seq_lookup = {1'b1, `TSQ_LEN_HL, `TSQ_SEQ_HL};
                {`TSQ_SDR, `TSQ_PIR}:
                    seq_lookup = {1'b1, `TSQ_LEN_TO_PIR, `TSQ_SEQ_TO_PIR};
                {`TSQ_SIR, `TSQ_PIR}: seq_lookup = {1'b1, `TSQ_LEN_HL, `TSQ_SEQ_HL};
                {`TSQ_SIR, `TSQ_PDR}:
                    seq_lookup = {1'b1, `TSQ_LEN_TO_PDR, `TSQ_SEQ_TO_PDR};
                // Entry moves, else nothing leaves Test-Logic-Reset after reset
                {`TSQ_TLR, `TSQ_SDR}: seq_lookup = {1'b1, `TSQ_LEN_TLR_SDR, `TSQ_SEQ_TLR_SDR};
                {`TSQ_TLR, `TSQ_PDR}: seq_lookup = {1'b1, `TSQ_LEN_TLR_PDR, `TSQ_SEQ_TLR_PDR};
                {`TSQ_TLR, `TSQ_SIR}: seq_lookup = {1'b1, `TSQ_LEN_TLR_SIR, `TSQ_SEQ_TLR_SIR};
                {`TSQ_TLR, `TSQ_PIR}: seq_lookup = {1'b1, `TSQ_LEN_TLR_PIR, `TSQ_SEQ_TLR_PIR};
                {`TSQ_RTI, `TSQ_SDR}: seq_lookup = {1'b1, `TSQ_LEN_RTI_SDR, `TSQ_SEQ_RTI_SDR};
                {`TSQ_RTI, `TSQ_PDR}: seq_lookup = {1'b1, `TSQ_LEN_RTI_PDR, `TSQ_SEQ_RTI_PDR};
                {`TSQ_RTI, `TSQ_SIR}: seq_lookup = {1'b1, `TSQ_LEN_RTI_SIR, `TSQ_SEQ_RTI_SIR};
                {`TSQ_RTI, `TSQ_PIR}: seq_lookup = {1'b1, `TSQ_LEN_RTI_PIR, `TSQ_SEQ_RTI_PIR};
                default: seq_lookup = 11'h000;
            endcase
        end
    endfunction

    // ----------------------------------------------------------------
    // State and next-state
    // ----------------------------------------------------------------
    tsq_state_t st_q;
    tsq_state_t st_d;
    logic tck_rise;
    logic tck_fall;
    logic in_shift;
    logic stall_go;
    logic resume_go;
    logic accept;
    logic [10:0] lut;

    assign tck_rise = st_q.tck_s2 & ~st_q.tck_s3;
    assign tck_fall = ~st_q.tck_s2 & st_q.tck_s3;
    assign in_shift = (st_q.tap == `TSQ_SDR) || (st_q.tap == `TSQ_SIR);
    assign stall_go = (st_q.mode == MODE_IDLE) & in_shift & buffer_stall & ~gated_mode;
    assign resume_go = (st_q.mode == MODE_HOLD) & (st_q.cnt == 3'h0) & ~buffer_stall;
    assign cmd_ready = (st_q.mode == MODE_IDLE) & ~stall_go;
    assign accept = cmd_valid & cmd_ready;
    assign lut = seq_lookup(st_q.tap, cmd_end_state);

    always_comb begin
        st_d = st_q;
        st_d.tck_s1 = tck;
        st_d.tck_s2 = st_q.tck_s1;
        st_d.tck_s3 = st_q.tck_s2;
        st_d.rejected = 1'b0;
        // Present next level on the falling edge, ahead of the rise
        if (tck_fall) begin
            if (st_q.cnt != 3'h0) begin
                st_d.tms = st_q.seq[0];
                st_d.presented = 1'b1;
            end else begin
                st_d.tms = (st_q.tap == `TSQ_TLR);
            end
        end
        // Record follows the targets on every rise
        if (tck_rise) begin
            st_d.tap = tap_next(st_q.tap, st_q.tms);
            if (st_q.presented) begin
                st_d.presented = 1'b0;
                st_d.seq = {1'b0, st_q.seq[6:1]};
                st_d.cnt = st_q.cnt - 3'h1;
                if (st_q.cnt == 3'h1 && st_q.mode == MODE_RUN) begin
                    st_d.mode = MODE_IDLE;
                end
            end
        end
        case (st_q.mode)
            MODE_IDLE: begin
                if (stall_go) begin
                    st_d.mode = MODE_HOLD;
                    st_d.seq = `TSQ_SEQ_HL;
                    st_d.cnt = `TSQ_LEN_HL;
                end else if (accept) begin
                    if (lut[10]) begin
                        st_d.mode = MODE_RUN;
                        st_d.cnt = lut[9:7];
                        st_d.seq = lut[6:0];
                    end else begin
                        st_d.rejected = 1'b1;
                    end
                end
            end
            MODE_RUN: begin
            end
            MODE_HOLD: begin
                if (resume_go) begin
                    st_d.mode = MODE_RUN;
                    st_d.seq = `TSQ_SEQ_HL;
                    st_d.cnt = `TSQ_LEN_HL;
                end
            end
            default: st_d.mode = MODE_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            st_q <= '{tck_s1: 1'b0, tck_s2: 1'b0, tck_s3: 1'b0, mode: MODE_IDLE,
                      tap: `TSQ_TLR, tms: 1'b1, seq: 7'h00, cnt: 3'h0,
                      presented: 1'b0, rejected: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign tms = st_q.tms;
    assign current_tap_state_field = st_q.tap;
    assign busy = (st_q.mode != MODE_IDLE);
    assign cmd_rejected = st_q.rejected;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    sequence s_idle_in(tsq_tap_t s);
        (st_q.mode == MODE_IDLE) && (st_q.cnt == 3'h0) && (st_q.tap == s);
    endsequence

    sequence s_accept_from(tsq_tap_t s, tsq_tap_t e);
        accept && (st_q.tap == s) && (cmd_end_state == e);
    endsequence

    property p_pdr_rest_low;
        s_idle_in(`TSQ_PDR) ##1 tck_rise |-> !tms;
    endproperty
    a_pdr_rest_low: assert property (p_pdr_rest_low) else $error("TMS high in Pause-DR");

    property p_pdr_to_pir;
        s_accept_from(`TSQ_PDR, `TSQ_PIR) |=> (st_q.cnt == 3'h7) && (st_q.seq == 7'h2f);
    endproperty
    a_pdr_to_pir: assert property (p_pdr_to_pir) else $error("Bad Pause-DR to Pause-IR");

    property p_pir_rest_low;
        s_idle_in(`TSQ_PIR) ##1 tck_rise |-> !tms;
    endproperty
    a_pir_rest_low: assert property (p_pir_rest_low) else $error("TMS high in Pause-IR");

    property p_pir_to_sdr;
        s_accept_from(`TSQ_PIR, `TSQ_SDR) |=> (st_q.cnt == 3'h5) && (st_q.seq == 7'h07);
    endproperty
    a_pir_to_sdr: assert property (p_pir_to_sdr) else $error("Bad Pause-IR to Shift-DR");

    property p_sdr_rest_low;
        s_idle_in(`TSQ_SDR) ##1 tck_rise |-> !tms;
    endproperty
    a_sdr_rest_low: assert property (p_sdr_rest_low) else $error("TMS high in Shift-DR");

    property p_sdr_to_pir;
        s_accept_from(`TSQ_SDR, `TSQ_PIR) |=> (st_q.cnt == 3'h7) && (st_q.seq == 7'h2f);
    endproperty
    a_sdr_to_pir: assert property (p_sdr_to_pir) else $error("Bad Shift-DR to Pause-IR");

    property p_sir_rest_low;
        s_idle_in(`TSQ_SIR) ##1 tck_rise |-> !tms;
    endproperty
    a_sir_rest_low: assert property (p_sir_rest_low) else $error("TMS high in Shift-IR");

    property p_sir_to_pdr;
        s_accept_from(`TSQ_SIR, `TSQ_PDR) |=> (st_q.cnt == 3'h6) && (st_q.seq == 7'h17);
    endproperty
    a_sir_to_pdr: assert property (p_sir_to_pdr) else $error("Bad Shift-IR to Pause-DR");

    property p_field_tracks;
        tck_rise |=> current_tap_state_field == tap_next($past(st_q.tap), $past(tms));
    endproperty
    a_field_tracks: assert property (p_field_tracks) else $error("State field wrong");

    property p_stall_pause;
        (stall_go ##1 (st_q.mode == MODE_HOLD)) |-> (st_q.cnt == 3'h2) && !cmd_ready;
    endproperty
    a_stall_pause: assert property (p_stall_pause) else $error("Stall did not pause");

    property p_gated_stay;
        (st_q.mode == MODE_IDLE) && in_shift && buffer_stall && gated_mode && !accept
            |=> (st_q.mode == MODE_IDLE) && in_shift;
    endproperty
    a_gated_stay: assert property (p_gated_stay) else $error("Gated stall left shift");

    property p_tap_on_rise;
        !tck_rise |=> $stable(st_q.tap);
    endproperty
    a_tap_on_rise: assert property (p_tap_on_rise) else $error("State moved off a rise");

    property p_tms_on_fall;
        !tck_fall |=> $stable(tms);
    endproperty
    a_tms_on_fall: assert property (p_tms_on_fall) else $error("TMS moved off a fall");

endmodule // tsq_sequencer

// *** tsq_regs.svh ***
// Constants for the TMS sequencer: TAP state codes and TMS sequences
`ifndef TSQ_REGS_SVH
`define TSQ_REGS_SVH

// ----------------------------------------------------------------
// TAP state codes, as shown in the state field
// ----------------------------------------------------------------
`define TSQ_TLR 4'hf
`define TSQ_RTI 4'hc
`define TSQ_SDRS 4'h7
`define TSQ_CDR 4'h6
`define TSQ_SDR 4'h2
`define TSQ_E1DR 4'h1
`define TSQ_PDR 4'h3
`define TSQ_E2DR 4'h0
`define TSQ_UDR 4'h5
`define TSQ_SIRS 4'h4
`define TSQ_CIR 4'he
`define TSQ_SIR 4'ha
`define TSQ_E1IR 4'h9
`define TSQ_PIR 4'hb
`define TSQ_E2IR 4'h8
`define TSQ_UIR 4'hd

// ----------------------------------------------------------------
// TMS sequences, first level in bit 0, with lengths
// ----------------------------------------------------------------
`define TSQ_SEQ_TLR 7'h1f
`define TSQ_LEN_TLR 3'h5
`define TSQ_SEQ_RTI 7'h03
`define TSQ_LEN_RTI 3'h3
`define TSQ_SEQ_HL 7'h01
`define TSQ_LEN_HL 3'h2
`define TSQ_SEQ_TO_PDR 7'h17
`define TSQ_LEN_TO_PDR 3'h6
`define TSQ_SEQ_PDR_SIR 7'h0f
`define TSQ_LEN_PDR_SIR 3'h6
`define TSQ_SEQ_TO_PIR 7'h2f
`define TSQ_LEN_TO_PIR 3'h7
`define TSQ_SEQ_PIR_SDR 7'h07
`define TSQ_LEN_PIR_SDR 3'h5

// ----------------------------------------------------------------
// Entry moves from Test-Logic-Reset and Run-Test/Idle
// ----------------------------------------------------------------
`define TSQ_SEQ_TLR_SDR 7'h02
`define TSQ_LEN_TLR_SDR 3'h4
`define TSQ_SEQ_TLR_PDR 7'h0a
`define TSQ_LEN_TLR_PDR 3'h5
`define TSQ_SEQ_TLR_SIR 7'h06
`define TSQ_LEN_TLR_SIR 3'h5
`define TSQ_SEQ_TLR_PIR 7'h16
`define TSQ_LEN_TLR_PIR 3'h6
`define TSQ_SEQ_RTI_SDR 7'h01
`define TSQ_LEN_RTI_SDR 3'h3
`define TSQ_SEQ_RTI_PDR 7'h05
`define TSQ_LEN_RTI_PDR 3'h4
`define TSQ_SEQ_RTI_SIR 7'h03
`define TSQ_LEN_RTI_SIR 3'h4
`define TSQ_SEQ_RTI_PIR 7'h0b
`define TSQ_LEN_RTI_PIR 3'h5

`endif

// *** tsq_pkg.sv ***
// Types for the TMS sequencer
package tsq_pkg;
    typedef logic [3:0] tsq_tap_t;

    typedef enum logic [2:0] {
        MODE_IDLE = 3'b001,
        MODE_RUN = 3'b010,
        MODE_HOLD = 3'b100
    } tsq_mode_t;

    typedef struct packed {
        logic tck_s1;
        logic tck_s2;
        logic tck_s3;
        tsq_mode_t mode;
        tsq_tap_t tap;
        logic tms;
        logic [6:0] seq;
        logic [2:0] cnt;
        logic presented;
        logic rejected;
    } tsq_state_t;
endpackage : tsq_pkg

// *** tsq_tap_model.sv ***
// Target TAP controller model stepping on every TCK rise
`include "tsq_regs.svh"

module tsq_tap_model (
    input wire logic tck,
    input wire logic trst_n,
    input wire logic tms,
    output tsq_pkg::tsq_tap_t tap_state
);
    timeunit 1ns;
    timeprecision 1ps;
    import tsq_pkg::*;

    // ------------------------------------------------------------
    // Sixteen-state graph
    // ------------------------------------------------------------
    function automatic tsq_tap_t step(input tsq_tap_t s, input logic t);
        case (s)
            `TSQ_TLR: return t ? `TSQ_TLR : `TSQ_RTI;
            `TSQ_RTI: return t ? `TSQ_SDRS : `TSQ_RTI;
            `TSQ_SDRS: return t ? `TSQ_SIRS : `TSQ_CDR;
            `TSQ_CDR, `TSQ_SDR: return t ? `TSQ_E1DR : `TSQ_SDR;
            `TSQ_E1DR: return t ? `TSQ_UDR : `TSQ_PDR;
            `TSQ_PDR: return t ? `TSQ_E2DR : `TSQ_PDR;
            `TSQ_E2DR: return t ? `TSQ_UDR : `TSQ_SDR;
            `TSQ_SIRS: return t ? `TSQ_TLR : `TSQ_CIR;
            `TSQ_CIR, `TSQ_SIR: return t ? `TSQ_E1IR : `TSQ_SIR;
            `TSQ_E1IR: return t ? `TSQ_UIR : `TSQ_PIR;
            `TSQ_PIR: return t ? `TSQ_E2IR : `TSQ_PIR;
            `TSQ_E2IR: return t ? `TSQ_UIR : `TSQ_SIR;
            default: return t ? `TSQ_SDRS : `TSQ_RTI;
        endcase
    endfunction

    always @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            tap_state <= `TSQ_TLR;
        end else begin
            tap_state <= step(tap_state, tms);
        end
    end
endmodule // tsq_tap_model

// *** tb_top.sv ***
// Self-checking bench for the TMS sequencer
`include "tsq_regs.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import tsq_pkg::*;

    logic core_clk, reset_n, tck, cmd_valid, buffer_stall, gated_mode;
    logic cmd_ready, cmd_rejected, tms, busy;
    tsq_tap_t cmd_end_state, field, tgt_state;
    int fails, checks_done, cycles, seed, exp_st;
    // Directed walk through every supported start and end pair, first nibble first
    localparam logic [111:0] route = 112'h332bb23b3a3fbabf2faf3cbc2cac;

    tsq_sequencer i_dut (.core_clk(core_clk), .reset_n(reset_n), .tck(tck),
        .cmd_valid(cmd_valid), .cmd_end_state(cmd_end_state), .cmd_ready(cmd_ready),
        .cmd_rejected(cmd_rejected), .buffer_stall(buffer_stall),
        .gated_mode(gated_mode), .tms(tms), .current_tap_state_field(field),
        .busy(busy));
    tsq_tap_model i_tap (.tck(tck), .trst_n(reset_n), .tms(tms), .tap_state(tgt_state));

    // ------------------------------------------------------------
    // Clocks and timeout
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    initial begin
        tck = 1'b0;
        #3.3;
        forever #24 tck = ~tck;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            $display("MISMATCH t=%0t timeout", $time);
            end_of_test();
        end
    end

    // ------------------------------------------------------------
    // Reference model and checks
    // ------------------------------------------------------------
    // Length in bits 11:8, TMS levels first-to-last from bit 0
    function automatic int lookup(input int s, input int e);
        if (s == `TSQ_TLR && e == `TSQ_SDR) return 32'h402;
        if (s == `TSQ_TLR && e == `TSQ_PDR) return 32'h50a;
        if (s == `TSQ_TLR && e == `TSQ_SIR) return 32'h506;
        if (s == `TSQ_TLR && e == `TSQ_PIR) return 32'h616;
        if (s == `TSQ_RTI && e == `TSQ_SDR) return 32'h301;
        if (s == `TSQ_RTI && e == `TSQ_PDR) return 32'h405;
        if (s == `TSQ_RTI && e == `TSQ_SIR) return 32'h403;
        if (s == `TSQ_RTI && e == `TSQ_PIR) return 32'h50b;
        if (!(s inside {`TSQ_PDR, `TSQ_PIR, `TSQ_SDR, `TSQ_SIR})) return 0;
        if (e == `TSQ_TLR) return 32'h51f;
        if (e == `TSQ_RTI) return 32'h303;
        if ((s == `TSQ_PDR && e == `TSQ_SDR) || (s == `TSQ_PIR && e == `TSQ_SIR) ||
            (s == `TSQ_SDR && e == `TSQ_PDR) || (s == `TSQ_SIR && e == `TSQ_PIR))
            return 32'h201;
        if (e == `TSQ_PIR && s != `TSQ_SIR) return 32'h72f;
        if (e == `TSQ_PDR && s != `TSQ_SDR) return 32'h617;
        if (s == `TSQ_PDR && e == `TSQ_SIR) return 32'h60f;
        if (s == `TSQ_PIR && e == `TSQ_SDR) return 32'h507;
        return 0;
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t %s seen=%h exp=%h", $time, msg, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic run_cmd(input tsq_tap_t e);
        int r;
        int n;
        n = 0;
        r = lookup(exp_st, e);
        @(posedge tck);
        @(negedge core_clk);
        while (cmd_ready !== 1'b1 && n < 200) begin
            @(negedge core_clk);
            n++;
        end
        check(cmd_ready, 1'b1, "ready");
        cmd_valid = 1'b1;
        cmd_end_state = e;
        @(negedge core_clk);
        cmd_valid = 1'b0;
        check(cmd_rejected, r == 0, "reject");
        check(busy, r != 0, "busy");
        if (r != 0) begin
            @(negedge tck);
            for (int i = 0; i < r / 256; i++) begin
                @(posedge tck);
                check(tms, (r >> i) & 1, "tms");
                repeat (6) @(negedge core_clk);
                check(field, tgt_state, "step");
            end
            exp_st = e;
            n = 0;
            while (busy !== 1'b0 && n < 200) begin
                @(negedge core_clk);
                n++;
            end
        end
        check(field, exp_st, "field");
        check(tgt_state, exp_st, "target");
        check(tms, exp_st == `TSQ_TLR, "rest");
    endtask

    // Buffer stall while resting in a shift state
    task automatic stall_case(input logic gated);
        int n;
        int hold_st;
        n = 0;
        hold_st = (exp_st == `TSQ_SDR) ? `TSQ_PDR : `TSQ_PIR;
        @(negedge core_clk);
        gated_mode = gated;
        buffer_stall = 1'b1;
        repeat (5) @(posedge tck);
        @(negedge core_clk);
        check(field, gated ? exp_st : hold_st, "stall field");
        check(tgt_state, gated ? exp_st : hold_st, "stall target");
        check(busy, !gated, "stall busy");
        check(tms, 1'b0, "stall tms");
        buffer_stall = 1'b0;
        while (busy !== 1'b0 && n < 200) begin
            @(negedge core_clk);
            n++;
        end
        check(field, exp_st, "resume field");
        check(tgt_state, exp_st, "resume target");
        gated_mode = 1'b0;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 56;
        exp_st = `TSQ_TLR;
        reset_n = 1'b0;
        cmd_valid = 1'b0;
        cmd_end_state = 4'h0;
        buffer_stall = 1'b0;
        gated_mode = 1'b0;
        for (int p = 0; p < 2; p++) begin
            repeat (8) @(negedge core_clk);
            reset_n = 1'b1;
            @(negedge core_clk);
            check(tms, 1'b1, "reset tms");
            check(field, `TSQ_TLR, "reset field");
            check(busy, 1'b0, "reset busy");
            for (int k = 0; k < 16; k++) run_cmd(k[3:0]);
            for (int j = 27; j >= 0; j--) run_cmd(route[4 * j +: 4]);
            repeat (20) begin
                // Free-running stalls are tried on their own below
                gated_mode = 1'($random(seed));
                buffer_stall = gated_mode & 1'($random(seed));
                run_cmd(4'($random(seed)));
            end
            buffer_stall = 1'b0;
            gated_mode = 1'b0;
            run_cmd(`TSQ_SDR);
            stall_case(1'b1);
            stall_case(1'b0);
            @(negedge core_clk);
            reset_n = 1'b0;
            exp_st = `TSQ_TLR;
        end
        end_of_test();
    end
endmodule // tb_top
